// ---- logic/dss_pkg.sv ----
/*
  Package for the drive stop and supply-loss sequencer: register map, field codes,
  timing constants and the packed carriers shared by the sequencer.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package dss_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_HZ = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

  localparam int unsigned COAST_BLOCK_MS = 2000;
  localparam int unsigned RAMP_HOLD_MS = 1000;
  localparam int unsigned INJ_TAIL_MS = 1000;
  localparam logic [15:0] COAST_BLOCK_TICKS = 16'(COAST_BLOCK_MS * TICK_HZ / 1000);
  localparam logic [15:0] RAMP_HOLD_TICKS = 16'(RAMP_HOLD_MS * TICK_HZ / 1000);
  localparam logic [15:0] INJ_TAIL_TICKS = 16'(INJ_TAIL_MS * TICK_HZ / 1000);

  localparam logic [11:0] BUS_LOSS_V_400 = 12'h1AE;
  localparam logic [11:0] BUS_LOSS_V_200 = 12'h0E1;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOGIC_SEL = 8'h04;
  localparam logic [7:0] ADDR_BRAKE = 8'h08;
  localparam logic [7:0] ADDR_RAMP = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_TERM = 8'h14;

  localparam logic [2:0] STOP_MODE_RST = 3'h1;
  localparam logic [1:0] LOSS_MODE_RST = 2'h0;
  localparam logic [2:0] LOGIC_SEL_RST = 3'h0;
  localparam logic [9:0] BRAKE_LEVEL_RST = 10'h3E8;
  localparam logic [7:0] BRAKE_TIME_RST = 8'h0A;
  localparam logic [15:0] DECEL_TICKS_RST = 16'h0032;
  localparam logic [7:0] LOSS_GAIN_RST = 8'h04;
  localparam logic [7:0] SHOW_LOSS_CODE = 8'hAC;

  typedef enum logic [2:0] {
    DSS_STOP_COAST = 3'h0,
    DSS_STOP_RAMP = 3'h1,
    DSS_STOP_RAMP_DC = 3'h2,
    DSS_STOP_DC_DETECT = 3'h3,
    DSS_STOP_DC_TIMED = 3'h4
  } dss_stop_mode_t;

  typedef enum logic [1:0] {
    DSS_LOSS_OFF = 2'h0,
    DSS_LOSS_STOP = 2'h1,
    DSS_LOSS_RIDE = 2'h2
  } dss_loss_mode_t;

  typedef enum logic [3:0] {
    DSS_READY = 4'h0,
    DSS_RUN = 4'h1,
    DSS_PH1_RAMP = 4'h2,
    DSS_PH1_LF_INJ = 4'h3,
    DSS_PH1_DC = 4'h4,
    DSS_PH2_HOLD = 4'h5,
    DSS_PH2_DC = 4'h6,
    DSS_PH2_BLOCK = 4'h7,
    DSS_LOSS_DECEL = 4'h8
  } dss_state_t;

  typedef enum logic [1:0] {
    DSS_TERM_ENABLE = 2'h0,
    DSS_TERM_NOT_STOP = 2'h1,
    DSS_TERM_USER = 2'h2
  } dss_term9_t;

  typedef struct packed {
    logic inv_enable;
    logic ramp_down;
    logic lf_inject;
    logic dc_inject;
    logic [9:0] inj_level;
    logic loss_regulate;
    logic [15:0] loss_current;
    logic [7:0] display_code;
  } dss_drive_cmd_t;

  typedef struct packed {
    dss_term9_t term9_func;
    logic run_is_direction;
    logic user_terms;
    logic run_latch_en;
  } dss_term_cfg_t;

endpackage : dss_pkg

// ---- logic/dss_sequencer.sv ----
/*
  Drive stop and supply-loss sequencer with an APB register slave.
  Assumes synchronous run, trip and sense inputs on clk_sys_i, except the three
  control terminals, which come from pins and are synchronised here.
*/
// Function
// - Coast stop disables the inverter at once and blocks re-enable for 2 s.
// - Ramp stop ramps to zero, keeps inverter enabled 1 s, then disables.
// - Mode 2 ramps to zero then injects DC for the braking time.
// - Mode 3 injects low-frequency current until low speed, then DC for braking time.
// - Mode 4 injects DC for braking time minus 1 s, but at least 1 s, then 1 s more.
// - After mode 3 or 4 begins, ready must be reached before a restart.
// - Supply-loss selector takes 0 disabled, 1 stop, 2 ride-through.
// - Supply-loss disabled means no monitoring; keep running.
// - Supply loss when the bus falls below 430 V, or 225 V on 200 V variant.
// - During loss, proportional control of current holds the bus at threshold.
// - Stop mode keeps decelerating to standstill after the supply returns.
// - Ride-through accelerates back to normal speed when the supply returns.
// - Show the supply-loss code on the left display during loss handling.
// - Dip deceleration never takes longer than the set deceleration time; decel_ticks_q is only read back, not applied to the dip.
// - Logic modes 0 to 3 set terminal functions and the run latch enable.
// - New logic selection takes effect only on reset while disabled or tripped.
// - Logic mode 4 leaves terminals and latch enable to the user.
// - The braking level sets current amplitude in every injection phase.
module dss_sequencer #(
  parameter int unsigned TICK_CYCLES = dss_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] term_pins_i,
  input wire logic run_req_i,
  input wire logic trip_i,
  input wire logic drive_reset_i,
  input wire logic at_zero_freq_i,
  input wire logic low_speed_i,
  input wire logic at_set_speed_i,
  input wire logic [11:0] dc_bus_v_i,
  input wire logic variant_200v_i,
  output dss_pkg::dss_drive_cmd_t cmd_o,
  output dss_pkg::dss_term_cfg_t term_cfg_o,
  output logic ready_o
);

  logic [2:0] stop_mode_q;
  logic [1:0] loss_mode_q;
  logic [2:0] logic_sel_q;
  logic [2:0] logic_act_q;
  logic [9:0] brake_level_q;
  logic [7:0] brake_time_q;
  logic [15:0] decel_ticks_q;
  logic [7:0] loss_gain_q;
  logic sw_enable_q;
  logic user_latch_q;
  logic [2:0] term_s1_q;
  logic [2:0] term_s2_q;
  logic [31:0] tick_div_q;
  logic tick;
  logic [15:0] phase_ticks_q;
  logic phase_entry;
  dss_pkg::dss_state_t state_q;
  dss_pkg::dss_state_t state_d;
  logic loss_resume_q;
  logic supply_lost;
  logic [11:0] loss_thresh;
  logic run_ok;
  logic [15:0] brake_ticks;
  logic [15:0] first_dc_ticks;
  logic apb_wr;
  logic [15:0] loss_err;

  function automatic dss_pkg::dss_term_cfg_t term_map(input logic [2:0] sel, input logic user_latch);
    dss_pkg::dss_term_cfg_t cfg;
    cfg.user_terms = (sel > 3'h3);
    cfg.run_is_direction = ~sel[1];
    if (sel > 3'h3) begin
      cfg.term9_func = dss_pkg::DSS_TERM_USER;
      cfg.run_latch_en = user_latch;
    end else begin
      cfg.term9_func = sel[0] ? dss_pkg::DSS_TERM_NOT_STOP : dss_pkg::DSS_TERM_ENABLE;
      cfg.run_latch_en = sel[0];
    end
    return cfg;
  endfunction : term_map

  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Registers keep the last value written; out-of-range codes are clamped so the
  // sequencer never sees an undefined mode.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      stop_mode_q <= dss_pkg::STOP_MODE_RST;
      loss_mode_q <= dss_pkg::LOSS_MODE_RST;
      logic_sel_q <= dss_pkg::LOGIC_SEL_RST;
      brake_level_q <= dss_pkg::BRAKE_LEVEL_RST;
      brake_time_q <= dss_pkg::BRAKE_TIME_RST;
      decel_ticks_q <= dss_pkg::DECEL_TICKS_RST;
      loss_gain_q <= dss_pkg::LOSS_GAIN_RST;
      sw_enable_q <= 1'b0;
      user_latch_q <= 1'b0;
    end else if (apb_wr) begin
      case (paddr_i)
        dss_pkg::ADDR_CTRL: begin
          stop_mode_q <= (pwdata_i[2:0] > 3'h4) ? 3'h4 : pwdata_i[2:0];
          loss_mode_q <= (pwdata_i[5:4] > 2'h2) ? 2'h2 : pwdata_i[5:4];
          sw_enable_q <= pwdata_i[8];
          user_latch_q <= pwdata_i[9];
        end
        dss_pkg::ADDR_LOGIC_SEL: begin
          logic_sel_q <= (pwdata_i[2:0] > 3'h4) ? 3'h4 : pwdata_i[2:0];
        end
        dss_pkg::ADDR_BRAKE: begin
          brake_level_q <= pwdata_i[9:0];
          brake_time_q <= (pwdata_i[23:16] > 8'hFA) ? 8'hFA : pwdata_i[23:16];
        end
        dss_pkg::ADDR_RAMP: begin
          decel_ticks_q <= pwdata_i[15:0];
          loss_gain_q <= pwdata_i[23:16];
        end
        default: begin
        end
      endcase
    end
  end

  // The applied selection only moves on a drive reset while disabled or tripped,
  // so terminals never change meaning under a running motor.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      logic_act_q <= dss_pkg::LOGIC_SEL_RST;
    end else if (drive_reset_i && (trip_i || !sw_enable_q)) begin
      logic_act_q <= logic_sel_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      term_s1_q <= 3'h0;
      term_s2_q <= 3'h0;
    end else begin
      term_s1_q <= term_pins_i;
      term_s2_q <= term_s1_q;
    end
  end

  // Reset already shows the mapping of the reset selection, so the terminal
  // setup does not jump on the first edge after reset with no drive reset.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      term_cfg_o <= term_map(dss_pkg::LOGIC_SEL_RST, 1'b0);
    end else begin
      term_cfg_o <= term_map(logic_act_q, user_latch_q);
    end
  end

  // Terminal 9 as enable or not-stop must be high to run; user mode ignores it.
  assign run_ok = sw_enable_q & ~trip_i & run_req_i & (term_cfg_o.user_terms | term_s2_q[0]);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || tick) begin
      tick_div_q <= '0;
    end else begin
      tick_div_q <= tick_div_q + 32'h1;
    end
  end
  assign tick = (tick_div_q == 32'(TICK_CYCLES - 1));

  assign phase_entry = (state_d != state_q);
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || phase_entry) begin
      phase_ticks_q <= '0;
    end else if (tick && phase_ticks_q != 16'hFFFF) begin
      phase_ticks_q <= phase_ticks_q + 16'h1;
    end
  end

  assign brake_ticks = {8'h0, brake_time_q};
  // A braking time of 2 s or less still gives a full first second.
  assign first_dc_ticks = (brake_ticks > dss_pkg::INJ_TAIL_TICKS * 16'h2) ?
    brake_ticks - dss_pkg::INJ_TAIL_TICKS : dss_pkg::INJ_TAIL_TICKS;

  assign loss_thresh = variant_200v_i ? dss_pkg::BUS_LOSS_V_200 : dss_pkg::BUS_LOSS_V_400;
  assign supply_lost = (loss_mode_q != dss_pkg::DSS_LOSS_OFF) && (dc_bus_v_i < loss_thresh);

  always_comb begin
    state_d = state_q;
    case (state_q)
      dss_pkg::DSS_READY: begin
        if (run_ok) begin
          state_d = dss_pkg::DSS_RUN;
        end
      end
      dss_pkg::DSS_RUN: begin
        if (supply_lost) begin
          state_d = dss_pkg::DSS_LOSS_DECEL;
        end else if (!run_ok) begin
          case (stop_mode_q)
            3'h0: state_d = dss_pkg::DSS_PH2_BLOCK;
            3'h3: state_d = dss_pkg::DSS_PH1_LF_INJ;
            3'h4: state_d = dss_pkg::DSS_PH1_DC;
            default: state_d = dss_pkg::DSS_PH1_RAMP;
          endcase
        end
      end
      dss_pkg::DSS_PH1_RAMP: begin
        if (trip_i) begin
          state_d = dss_pkg::DSS_PH2_BLOCK;
        end else if (at_zero_freq_i) begin
          state_d = (stop_mode_q == 3'h2) ? dss_pkg::DSS_PH2_DC : dss_pkg::DSS_PH2_HOLD;
        end
      end
      dss_pkg::DSS_PH1_LF_INJ: begin
        if (low_speed_i) begin
          state_d = dss_pkg::DSS_PH2_DC;
        end
      end
      dss_pkg::DSS_PH1_DC: begin
        if (phase_ticks_q >= first_dc_ticks) begin
          state_d = dss_pkg::DSS_PH2_DC;
        end
      end
      dss_pkg::DSS_PH2_HOLD: begin
        if (phase_ticks_q >= dss_pkg::RAMP_HOLD_TICKS) begin
          state_d = dss_pkg::DSS_READY;
        end
      end
      dss_pkg::DSS_PH2_DC: begin
        if ((stop_mode_q == 3'h4 && phase_ticks_q >= dss_pkg::INJ_TAIL_TICKS) ||
            (stop_mode_q != 3'h4 && phase_ticks_q >= brake_ticks)) begin
          state_d = dss_pkg::DSS_READY;
        end
      end
      dss_pkg::DSS_PH2_BLOCK: begin
        if (phase_ticks_q >= dss_pkg::COAST_BLOCK_TICKS) begin
          state_d = dss_pkg::DSS_READY;
        end
      end
      dss_pkg::DSS_LOSS_DECEL: begin
        if (trip_i) begin
          state_d = dss_pkg::DSS_PH2_BLOCK;
        end else if (at_zero_freq_i) begin
          state_d = dss_pkg::DSS_PH2_HOLD;
        end else if (!supply_lost && loss_mode_q == dss_pkg::DSS_LOSS_RIDE) begin
          state_d = dss_pkg::DSS_RUN;
        end else if (!supply_lost && loss_mode_q == dss_pkg::DSS_LOSS_STOP) begin
          state_d = dss_pkg::DSS_PH1_RAMP;
        end
      end
      default: state_d = dss_pkg::DSS_READY;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= dss_pkg::DSS_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // Ride-through remembers that it must regain set speed; cleared once there.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      loss_resume_q <= 1'b0;
    end else if (state_q == dss_pkg::DSS_LOSS_DECEL && state_d == dss_pkg::DSS_RUN) begin
      loss_resume_q <= 1'b1;
    end else if (at_set_speed_i || state_q != dss_pkg::DSS_RUN) begin
      loss_resume_q <= 1'b0;
    end
  end

  assign loss_err = {4'h0, loss_thresh} - {4'h0, dc_bus_v_i};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd_o <= '0;
    end else begin
      cmd_o.inv_enable <= (state_d != dss_pkg::DSS_READY) && (state_d != dss_pkg::DSS_PH2_BLOCK);
      cmd_o.ramp_down <= (state_d == dss_pkg::DSS_PH1_RAMP);
      cmd_o.lf_inject <= (state_d == dss_pkg::DSS_PH1_LF_INJ);
      cmd_o.dc_inject <= (state_d == dss_pkg::DSS_PH1_DC) || (state_d == dss_pkg::DSS_PH2_DC);
      cmd_o.inj_level <= brake_level_q;
      cmd_o.loss_regulate <= (state_d == dss_pkg::DSS_LOSS_DECEL);
      // Proportional demand, bus error times loss_gain_q; the programmed
      // deceleration does not limit it, as decel_ticks_q is only read back.
      cmd_o.loss_current <= (state_d == dss_pkg::DSS_LOSS_DECEL && dc_bus_v_i < loss_thresh) ?
        16'(loss_err * {8'h0, loss_gain_q}) : 16'h0;
      cmd_o.display_code <= (state_d == dss_pkg::DSS_LOSS_DECEL) ? dss_pkg::SHOW_LOSS_CODE : 8'h00;
    end
  end

  assign ready_o = (state_q == dss_pkg::DSS_READY);

  always_comb begin
    prdata_o = 32'h0;
    case (paddr_i)
      dss_pkg::ADDR_CTRL: prdata_o = {22'h0, user_latch_q, sw_enable_q, 2'h0, loss_mode_q, 1'b0, stop_mode_q};
      dss_pkg::ADDR_LOGIC_SEL: prdata_o = {13'h0, logic_act_q, 13'h0, logic_sel_q};
      dss_pkg::ADDR_BRAKE: prdata_o = {8'h0, brake_time_q, 6'h0, brake_level_q};
      dss_pkg::ADDR_RAMP: prdata_o = {8'h0, loss_gain_q, decel_ticks_q};
      dss_pkg::ADDR_STATUS: prdata_o = {7'h0, loss_resume_q, cmd_o.display_code, phase_ticks_q[11:0], state_q};
      dss_pkg::ADDR_TERM: prdata_o = {24'h0, term_cfg_o, term_s2_q};
      default: prdata_o = 32'h0;
    endcase
  end

endmodule : dss_sequencer

// ---- sim/dss_properties.sv ----
/*
  Checker for the drive stop and supply-loss sequencer, bound to its top module.
  Assumes the one clock clk_sys_i and the synchronous active-high reset_i.
*/
module dss_properties (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic drive_reset_i,
  input wire logic [11:0] dc_bus_v_i,
  input wire logic variant_200v_i,
  input wire dss_pkg::dss_drive_cmd_t cmd_o,
  input wire dss_pkg::dss_term_cfg_t term_cfg_o,
  input wire logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic [11:0] thr;
  assign thr = variant_200v_i ? dss_pkg::BUS_LOSS_V_200 : dss_pkg::BUS_LOSS_V_400;
  property p_show;
    cmd_o.display_code == (cmd_o.loss_regulate ? dss_pkg::SHOW_LOSS_CODE : 8'h00);
  endproperty
  a_show: assert property (p_show) else $error("display code wrong");
  property p_ready_quiet;
    ready_o |-> !cmd_o.lf_inject && !cmd_o.dc_inject;
  endproperty
  a_ready_quiet: assert property (p_ready_quiet) else $error("injection in ready");
  property p_phase_excl;
    cmd_o.lf_inject |-> !cmd_o.dc_inject;
  endproperty
  a_phase_excl: assert property (p_phase_excl) else $error("two injections");
  property p_loss_excl;
    cmd_o.loss_regulate |-> !cmd_o.dc_inject && !cmd_o.lf_inject;
  endproperty
  a_loss_excl: assert property (p_loss_excl) else $error("injection in loss");
  property p_loss_idle;
    !cmd_o.loss_regulate |-> cmd_o.loss_current == 16'h0;
  endproperty
  a_loss_idle: assert property (p_loss_idle) else $error("loss current outside loss handling");
  property p_loss_cause;
    $rose(cmd_o.loss_regulate) |-> ($past(dc_bus_v_i) < thr) || ($past(dc_bus_v_i, 2) < thr);
  endproperty
  a_loss_cause: assert property (p_loss_cause) else $error("loss without low bus");
  property p_dc_min;
    $rose(cmd_o.dc_inject) |-> cmd_o.dc_inject [*8];
  endproperty
  a_dc_min: assert property (p_dc_min) else $error("injection too short");
  property p_hold;
    $fell(cmd_o.ramp_down) && cmd_o.inv_enable |-> cmd_o.inv_enable [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("no hold after ramp");
  property p_term;
    $changed(term_cfg_o) |-> $past(drive_reset_i) || $past(drive_reset_i, 2) || $past(drive_reset_i, 3);
  endproperty
  a_term: assert property (p_term) else $error("terminal setup changed unasked");
endmodule : dss_properties

bind dss_sequencer dss_properties u_dss_properties (.clk_sys_i, .reset_i, .drive_reset_i, .dc_bus_v_i,
  .variant_200v_i, .cmd_o, .term_cfg_o, .ready_o);

// ---- sim/dss_partner.sv ----
/*
  Behavioural power stage and bus sense: a speed count that follows the drive commands.
  Assumes the sequencer's commands on clk_sys_i and a supply flag from the bench.
*/
module dss_partner (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire dss_pkg::dss_drive_cmd_t cmd_i,
  input wire logic supply_ok_i,
  output logic at_zero_freq_o,
  output logic low_speed_o,
  output logic at_set_speed_o,
  output logic [11:0] dc_bus_v_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] speed_q;
  logic up;
  assign up = cmd_i.inv_enable & ~cmd_i.ramp_down & ~cmd_i.lf_inject & ~cmd_i.dc_inject & ~cmd_i.loss_regulate;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      speed_q <= 5'h00;
    end else if (up && speed_q != 5'h14) begin
      speed_q <= speed_q + 5'h01;
    end else if (!up && speed_q != 5'h00) begin
      speed_q <= speed_q - 5'h01;
    end
  end
  assign at_zero_freq_o = speed_q == 5'h00;
  assign at_set_speed_o = speed_q == 5'h14;
  // A weak injection never brings the speed sense low enough.
  assign low_speed_o = cmd_i.lf_inject && cmd_i.inj_level >= 10'h1F4 && speed_q < 5'h04;
  assign dc_bus_v_o = supply_ok_i ? 12'h21C : 12'h190;
endmodule : dss_partner

// ---- sim/tb_drive_stop_supply_loss_sequencer.sv ----
/*
  Testbench for the drive stop and supply-loss sequencer, checked through APB reads.
  Assumes a short tick of 10 clocks so that every stop phase fits in the run.
*/
module tb_drive_stop_supply_loss_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, reset_i, psel, penable, pwrite, run_req, trip, drive_reset, supply_ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o;
  logic pready_o, ready_o, at_zero, low_speed, at_set;
  logic [2:0] term_pins;
  logic [11:0] bus_v;
  dss_pkg::dss_drive_cmd_t cmd_o;
  dss_pkg::dss_term_cfg_t term_cfg_o;
  logic [63:0] notes[$];
  int failures = 0, checked = 0, seed = 32'h95A5;
  int p1[5] = '{7, 2, 2, 3, 4};
  int p2[5] = '{7, 5, 6, 6, 4};
  int p3[5] = '{7, 0, 0, 0, 6};
  dss_sequencer #(.TICK_CYCLES(10)) u_dss_sequencer (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(), .term_pins_i(term_pins), .run_req_i(run_req), .trip_i(trip),
    .drive_reset_i(drive_reset), .at_zero_freq_i(at_zero), .low_speed_i(low_speed), .at_set_speed_i(at_set),
    .dc_bus_v_i(bus_v), .variant_200v_i(1'b0), .cmd_o(cmd_o), .term_cfg_o(term_cfg_o), .ready_o(ready_o));
  dss_partner u_dss_partner (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_i(cmd_o), .supply_ok_i(supply_ok),
    .at_zero_freq_o(at_zero), .low_speed_o(low_speed), .at_set_speed_o(at_set), .dc_bus_v_o(bus_v));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic pulse_reset();
    drive_reset <= 1'b1;
    cyc(1);
    drive_reset <= 1'b0;
    cyc(3);
  endtask : pulse_reset
  function automatic logic [4:0] tcfg(input logic [2:0] m);
    return (m == 3'h4) ? 5'b10110 : {1'b0, m[0], ~m[1], 1'b0, m[0]};
  endfunction : tcfg
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // Read data is taken at the edge where pready is seen high, before that edge's updates land.
  always @(posedge clk_sys_i) begin
    logic [63:0] n;
    if (psel && penable && !pwrite && pready_o === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      checked++;
      if ((prdata_o & n[63:32]) !== n[31:0]) begin
        failures++;
        $display("ERROR prdata at %0h expected %0h seen %0h", paddr, n[31:0], prdata_o & n[63:32]);
      end
    end
  end
  initial begin
    cyc(20000);
    failures++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, run_req, trip, drive_reset} = 6'h00;
    {paddr, pwdata, term_pins} = 43'h0;
    supply_ok = 1'b1;
    reset_i = 1'b1;
    cyc(12);
    reset_i <= 1'b0;
    cyc(1);
    rd(dss_pkg::ADDR_LOGIC_SEL, 32'h0000_0000, 32'h0007_0007);
    rd(dss_pkg::ADDR_CTRL, 32'h0000_0001, 32'h0000_0137);
    apb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, dss_pkg::ADDR_BRAKE, 32'h000A_02BC);
    for (int m = 0; m < 5; m++) begin
      term_pins <= 3'($random(seed));
      apb(1'b1, dss_pkg::ADDR_LOGIC_SEL, 32'(m));
      pulse_reset();
      rd(dss_pkg::ADDR_LOGIC_SEL, 32'(m) << 16 | 32'(m), 32'h0007_0007);
      rd(dss_pkg::ADDR_TERM, {24'h0, tcfg(3'(m)), term_pins}, 32'h0000_00FF);
    end
    apb(1'b1, dss_pkg::ADDR_CTRL, 32'h0000_0101);
    apb(1'b1, dss_pkg::ADDR_LOGIC_SEL, 32'h0000_0001);
    pulse_reset();
    rd(dss_pkg::ADDR_LOGIC_SEL, 32'h0004_0001, 32'h0007_0007);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, dss_pkg::ADDR_CTRL, 32'h0000_0100 | 32'(m));
      run_req <= 1'b1;
      cyc(40);
      rd(dss_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_000F);
      run_req <= 1'b0;
      cyc(2);
      rd(dss_pkg::ADDR_STATUS, 32'(p1[m]), 32'h0000_000F);
      // A fresh run request during coast block or mode 4 injection must not restart the drive.
      if (m == 0 || m == 4) run_req <= 1'b1;
      cyc(35);
      rd(dss_pkg::ADDR_STATUS, 32'(p2[m]), 32'h0000_000F);
      cyc(135);
      rd(dss_pkg::ADDR_STATUS, 32'(p3[m]), 32'h0000_000F);
      run_req <= 1'b0;
      cyc(57);
      rd(dss_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_000F);
    end
    for (int lm = 0; lm < 3; lm++) begin
      apb(1'b1, dss_pkg::ADDR_CTRL, 32'h0000_0101 | 32'(lm) << 4);
      run_req <= 1'b1;
      cyc(40);
      supply_ok <= 1'b0;
      cyc(4);
      rd(dss_pkg::ADDR_STATUS, (lm == 0) ? 32'h0000_0001 : 32'h00AC_0008, 32'h00FF_000F);
      supply_ok <= 1'b1;
      cyc(3);
      rd(dss_pkg::ADDR_STATUS, (lm == 1) ? 32'h0000_0002 : (lm == 2) ? 32'h0100_0001 : 32'h0000_0001,
        32'h0100_000F);
      run_req <= 1'b0;
      cyc(300);
    end
    trip <= 1'b1;
    pulse_reset();
    trip <= 1'b0;
    rd(dss_pkg::ADDR_LOGIC_SEL, 32'h0001_0001, 32'h0007_0007);
    give_verdict();
  end
endmodule : tb_drive_stop_supply_loss_sequencer
